// ### design/eodu_defines.svh
// Constants for the escape opcode decoder, upper half of the escape map
`ifndef EODU_DEFINES_SVH
`define EODU_DEFINES_SVH
`define EODU_ESCAPE_BYTE      8'h0F
`define EODU_UNDEF_SECOND     8'h0B
`define EODU_INVALID_SECOND   8'hB9
`define EODU_JCC_HI           5'h11
`define EODU_SETCC_HI         5'h13
`define EODU_SHIFT_GROUP_HI   6'h1C
`define EODU_SHIFT_WORD       8'h71
`define EODU_SHIFT_DWORD      8'h72
`define EODU_SHIFT_QWORD      8'h73
`define EODU_BIT_GROUP        8'hBA
`define EODU_SEL_MSB          5
`define EODU_SEL_LSB          3
`define EODU_SEL_SRL          3'h2
`define EODU_SEL_SRA          3'h4
`define EODU_SEL_SLL          3'h6
`define EODU_SEL_BT_FIRST     3'h4
`define EODU_COND_SIGN        4'h8
`define EODU_COND_IDX_MSB     2
`define EODU_COND_IDX_LSB     0
`define EODU_COND_IDX_MASK    4'h7
`define EODU_ROW_MSB          7
`define EODU_ROW_LSB          3
`define EODU_GRP_LSB          2
`define EODU_GRP_SUB_MSB      1
`define EODU_GRP_SUB_LSB      0
`define EODU_SHIFT_HOLE       2'h0
`define EODU_SEL_WIDTH        3
`define EODU_SEL_NONE         4'h0
`define EODU_RESET_BYTE       8'h00
`endif

// ### design/eodu_pkg.sv
// Types shared by the escape opcode decoder files
package eodu_pkg;
    typedef enum logic [2:0] {
        EODU_OP_NONE,
        EODU_OP_JCC,
        EODU_OP_SETCC,
        EODU_OP_SHIFT_IMM,
        EODU_OP_BIT_TEST,
        EODU_OP_FAULT
    } eodu_class_e;
    typedef enum logic [1:0] {
        EODU_FORM_NONE,
        EODU_FORM_DISP,
        EODU_FORM_BYTE_RM,
        EODU_FORM_RM_IMM
    } eodu_form_e;
    typedef enum logic [1:0] {
        EODU_ST_IDLE,
        EODU_ST_ESCAPED,
        EODU_ST_NEED_SPEC
    } eodu_state_e;
endpackage : eodu_pkg

// ### design/eodu_group_sel.sv
// Operand-specifier group decode for shift and bit-test groups
`timescale 1ns/1ns
`default_nettype none
`include "eodu_defines.svh"
module eodu_group_sel
    import eodu_pkg::*;
(
    input  wire logic [7:0] second_byte,
    input  wire logic [7:0] operand_specifier_byte,
    output logic            legal,
    output logic [3:0]      selector
);
    logic [2:0] sel;

    // Field 5..3 picks the member of the group
    assign sel = operand_specifier_byte[`EODU_SEL_MSB:`EODU_SEL_LSB]; // RULE3

    // Quadword group lacks arithmetic right; others reserved
    always_comb begin
        legal    = 1'b0;
        selector = {1'b0, sel};
        if (second_byte == `EODU_BIT_GROUP) begin
            legal = (sel >= `EODU_SEL_BT_FIRST);
        end else if (second_byte == `EODU_SHIFT_QWORD) begin
            legal = (sel == `EODU_SEL_SRL) || (sel == `EODU_SEL_SLL); // RULE4
        end else if (second_byte == `EODU_SHIFT_WORD || second_byte == `EODU_SHIFT_DWORD) begin
            legal = (sel == `EODU_SEL_SRL) || (sel == `EODU_SEL_SRA) || (sel == `EODU_SEL_SLL); // RULE4
        end
    end
endmodule : eodu_group_sel
`default_nettype wire

// ### design/eodu_decoder.sv
// Escape opcode decoder for the upper half of the two-byte map
`timescale 1ns/1ns
`default_nettype none
`include "eodu_defines.svh"
// Overview of operation
// RULE1 - Byte 0F escapes to the two-byte map
// RULE2 - Unassigned two-byte positions are reserved, faulting
// RULE3 - Group member chosen by specifier bits 5..3
// RULE4 - Word/dword shifts three kinds, quadword two
// RULE5 - 0F0B and 0FB9 raise invalid opcode
// RULE6 - 88..8F long jumps, sign through greater
// RULE7 - 98..9F set byte, same condition order
// RULE8 - Software must not rely on undefined opcodes
// RULE9 - Class, selector and form in one cycle
module eodu_decoder
    import eodu_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic             decode_valid,
    output eodu_class_e      op_class,
    output logic [3:0]       op_selector,
    output eodu_form_e       op_form,
    output logic             invalid_opcode_exception
);
    // All state in one packed word: the sequencer position, the held
    // second byte, and the result fields the execute stage reads. One
    // register keeps every field on the same edge.
    typedef struct packed {
        eodu_state_e state;
        logic [7:0]  second;
        logic        valid;
        eodu_class_e cls;
        logic [3:0]  sel;
        eodu_form_e  form;
        logic        fault;
    } eodu_state_s;

    // Sequencer state
    eodu_state_s cur;
    eodu_state_s next_cur;

    // Escape detection and second-byte classification
    logic        is_escape;
    logic        is_jcc;
    logic        is_setcc;
    logic        is_shift_group;
    logic        is_bit_group;
    logic        is_group;
    logic        is_undef;
    logic [3:0]  cond_code;

    // Specifier stage
    logic        grp_legal;
    logic [3:0]  grp_sel;
    logic [7:0]  grp_second;
    logic        spec_is_bit;
    eodu_class_e spec_cls;
    eodu_form_e  spec_form;
    logic        spec_fault;

    // Guard the header constants the decode leans on: the condition base
    // must leave the index bits clear so the OR acts as an add, and the
    // specifier field must be exactly as wide as the group selector index.
    if ((`EODU_COND_SIGN & `EODU_COND_IDX_MASK) != 4'h0) begin : g_bad_cond_base
        $error("condition base overlaps the index bits");
    end
    if ((`EODU_SEL_MSB - `EODU_SEL_LSB + 1) != `EODU_SEL_WIDTH) begin : g_bad_sel_field
        $error("specifier field width does not match the selector");
    end

    // Reset image of the whole state; every field a named constant except the valid and fault strobes, which are literal zeros
    localparam eodu_state_s EODU_RESET_STATE = '{
        state:  EODU_ST_IDLE,
        second: `EODU_RESET_BYTE,
        valid:  1'b0,
        cls:    EODU_OP_NONE,
        sel:    `EODU_SEL_NONE,
        form:   EODU_FORM_NONE,
        fault:  1'b0
    };

    // Escape detection in idle; any other byte arriving there is dropped,
    // since a stray byte without its escape has no meaning to this block
    assign is_escape = byte_valid && (byte_data == `EODU_ESCAPE_BYTE); // RULE1

    // Second-byte classification straight off the fetch bus. Kept apart
    // from the sequencer so each region of the map reads as one line and
    // no priority between regions can hide inside the state logic.
    always_comb begin
        // Rows 8 and 9 of the upper half
        is_jcc         = (byte_data[`EODU_ROW_MSB:`EODU_ROW_LSB] == `EODU_JCC_HI); // RULE6
        is_setcc       = (byte_data[`EODU_ROW_MSB:`EODU_ROW_LSB] == `EODU_SETCC_HI); // RULE7
        // Row 7 columns 1..3; column 0 of that row is a hole
        is_shift_group = (byte_data[`EODU_ROW_MSB:`EODU_GRP_LSB] == `EODU_SHIFT_GROUP_HI)
                         && (byte_data[`EODU_GRP_SUB_MSB:`EODU_GRP_SUB_LSB] != `EODU_SHIFT_HOLE); // RULE4
        is_bit_group   = (byte_data == `EODU_BIT_GROUP); // RULE3
        is_group       = is_shift_group || is_bit_group; // RULE3
        // 0B and B9 fault on purpose; decoded apart so a later change to
        // the reserved-map policy cannot swallow them
        is_undef       = (byte_data == `EODU_UNDEF_SECOND) || (byte_data == `EODU_INVALID_SECOND); // RULE5
        // Low three bits index sign..greater, the upper eight condition codes
        cond_code      = `EODU_COND_SIGN | {1'b0, byte_data[`EODU_COND_IDX_MSB:`EODU_COND_IDX_LSB]};
    end

    // Group check looks at the held second byte during the specifier fetch
    assign grp_second  = cur.second;
    assign spec_is_bit = (cur.second == `EODU_BIT_GROUP);

    eodu_group_sel u_group (
        .second_byte            (grp_second),
        .operand_specifier_byte (byte_data),
        .legal                  (grp_legal),
        .selector               (grp_sel)
    );

    // Specifier-stage result. An illegal member faults rather than running
    // a neighbouring operation; a later core may give those members meaning,
    // so nothing here may be relied on beyond the fault itself.
    always_comb begin
        spec_cls   = spec_is_bit ? EODU_OP_BIT_TEST : EODU_OP_SHIFT_IMM;
        spec_form  = EODU_FORM_RM_IMM;
        spec_fault = 1'b0;
        if (!grp_legal) begin
            spec_cls   = EODU_OP_FAULT; // RULE2
            spec_form  = EODU_FORM_NONE;
            spec_fault = 1'b1;
        end
    end

    // Decode sequencing. Strobes default low every cycle so a result stands
    // exactly one cycle; class, selector and form otherwise keep their last
    // value, which lets the execute stage look at them late.
    always_comb begin
        next_cur       = cur;
        next_cur.valid = 1'b0;
        next_cur.fault = 1'b0;
        case (cur.state)
            // Idle: only the escape byte is taken
            EODU_ST_IDLE: begin
                if (is_escape) begin
                    next_cur.state = EODU_ST_ESCAPED; // RULE1
                end
            end

            // Escaped: the second byte picks the map region
            EODU_ST_ESCAPED: begin
                if (byte_valid) begin
                    next_cur.second = byte_data;
                    next_cur.state  = EODU_ST_IDLE;
                    if (is_jcc) begin
                        next_cur.valid = 1'b1; // RULE9
                        next_cur.cls   = EODU_OP_JCC; // RULE6
                        next_cur.sel   = cond_code; // RULE6
                        next_cur.form  = EODU_FORM_DISP;
                    end else if (is_setcc) begin
                        next_cur.valid = 1'b1; // RULE9
                        next_cur.cls   = EODU_OP_SETCC; // RULE7
                        next_cur.sel   = cond_code; // RULE7
                        next_cur.form  = EODU_FORM_BYTE_RM;
                    end else if (is_group) begin
                        // Result waits for the specifier byte; the last
                        // result stays on the outputs untouched meanwhile
                        next_cur.state = EODU_ST_NEED_SPEC; // RULE3
                    end else if (is_undef) begin
                        // Deliberate fault encodings
                        next_cur.valid = 1'b1; // RULE9
                        next_cur.cls   = EODU_OP_FAULT; // RULE5
                        next_cur.sel   = `EODU_SEL_NONE;
                        next_cur.form  = EODU_FORM_NONE;
                        next_cur.fault = 1'b1; // RULE5
                    end else begin
                        // Reserved or outside this half: fault, no guarantees
                        next_cur.valid = 1'b1; // RULE9
                        next_cur.cls   = EODU_OP_FAULT; // RULE2
                        next_cur.sel   = `EODU_SEL_NONE;
                        next_cur.form  = EODU_FORM_NONE;
                        next_cur.fault = 1'b1; // RULE2
                    end
                end
            end

            // Awaiting the specifier byte of a group
            EODU_ST_NEED_SPEC: begin
                if (byte_valid) begin
                    // Selector passes through even on a fault; only class,
                    // form and the fault strobe tell a fault apart
                    next_cur.state = EODU_ST_IDLE;
                    next_cur.valid = 1'b1; // RULE9
                    next_cur.sel   = grp_sel; // RULE3
                    next_cur.cls   = spec_cls;
                    next_cur.form  = spec_form;
                    next_cur.fault = spec_fault; // RULE2
                end
            end

            default: begin
                next_cur.state = EODU_ST_IDLE;
            end
        endcase
    end

    // State register; the reset branch loads one constant image so no
    // field can come out of reset holding a derived value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= EODU_RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    // Result strobes, one cycle each
    assign decode_valid             = cur.valid; // RULE9
    assign invalid_opcode_exception = cur.fault; // RULE5

    // Held result fields, all straight from flip-flops
    assign op_class                 = cur.cls;
    assign op_selector              = cur.sel;
    assign op_form                  = cur.form;
endmodule : eodu_decoder
`default_nettype wire

// ### verification/eodu_decoder_props.sv
// Checker for the escape opcode decoder result ports
`timescale 1ns/1ns
`default_nettype none
module eodu_decoder_props
    import eodu_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        byte_valid,
    input wire logic [7:0]  byte_data,
    input wire logic        decode_valid,
    input wire logic [2:0]  op_class,
    input wire logic [3:0]  op_selector,
    input wire logic [1:0]  op_form,
    input wire logic        invalid_opcode_exception
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A result is always launched by a byte taken at the edge before
    taken_byte_a: assert property (decode_valid |-> $past(byte_valid)) else $error("result without byte");
    exc_pair_a: assert property (invalid_opcode_exception == (decode_valid && op_class == EODU_OP_FAULT))
        else $error("fault pulse wrong");
    single_pulse_a: assert property (decode_valid |=> !decode_valid) else $error("result too long");
    // Results hold between pulses so the execute stage may sample late
    class_hold_a: assert property (!decode_valid |-> $stable(op_class) && $stable(op_selector))
        else $error("result moved");
    jcc_cond_a: assert property (decode_valid && op_class == EODU_OP_JCC |-> op_form == EODU_FORM_DISP
        && op_selector == $past(byte_data[3:0]) && $past(byte_data[7:4]) == 4'h8) else $error("jump wrong");
    setcc_cond_a: assert property (decode_valid && op_class == EODU_OP_SETCC |-> op_form == EODU_FORM_BYTE_RM
        && op_selector == $past(byte_data[3:0]) && $past(byte_data[7:4]) == 4'h9) else $error("set wrong");
    shift_sel_a: assert property (decode_valid && op_class == EODU_OP_SHIFT_IMM |-> op_selector inside {4'h2, 4'h4,
        4'h6} && op_selector[2:0] == $past(byte_data[5:3])) else $error("shift wrong");
    bit_sel_a: assert property (decode_valid && op_class == EODU_OP_BIT_TEST |-> op_selector[3:2] == 2'h1
        && op_selector[2:0] == $past(byte_data[5:3])) else $error("bit group wrong");
endmodule : eodu_decoder_props
bind eodu_decoder eodu_decoder_props u_props (.clk_sys, .rst, .byte_valid, .byte_data, .decode_valid,
    .op_class, .op_selector, .op_form, .invalid_opcode_exception);
`default_nettype wire

// ### verification/eodu_fetch_model.sv
// Fetch unit model handing opcode bytes to the decoder
`timescale 1ns/1ns
`default_nettype none
module eodu_fetch_model (
    input  wire logic  clk_sys,
    output logic       byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end
    // One byte offered for one edge
    task put(input logic [7:0] b);
        @(negedge clk_sys);
        byte_valid <= 1'b1;
        byte_data  <= b;
    endtask : put
    // Scrambled data while idle so a stale byte never looks valid
    task gap();
        @(negedge clk_sys);
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
    endtask : gap
endmodule : eodu_fetch_model
`default_nettype wire

// ### verification/eodu_decoder_tb.sv
// Self-checking bench for the escape opcode decoder
`timescale 1ns/1ns
`default_nettype none
module eodu_decoder_tb
    import eodu_pkg::*;
;
    logic        clk_sys, rst, byte_valid, decode_valid, invalid_opcode_exception;
    logic [7:0]  byte_data;
    logic [3:0]  op_selector;
    eodu_class_e op_class;
    eodu_form_e  op_form;
    int          bad_count = 0, total_checks = 0;
    eodu_fetch_model fm (.clk_sys, .byte_valid, .byte_data);
    eodu_decoder uut (.clk_sys, .rst, .byte_valid, .byte_data, .decode_valid, .op_class, .op_selector,
        .op_form, .invalid_opcode_exception);
    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task summarize();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task chk(input string n, input logic [3:0] s, input logic [3:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // Escape, second byte, optional specifier, then judge the result
    task run(input logic [7:0] b2, input logic [7:0] sp, input logic g, input logic [2:0] c, input logic [3:0] sl);
        logic [2:0] pc;
        pc = op_class;
        fm.put(8'h0F);
        fm.put(b2);
        if (g) begin
            fm.put(sp);
            chk("hold", 4'(op_class), 4'(pc));
        end
        fm.gap();
        for (int n = 0; n < 3 && decode_valid !== 1'b1; n++) @(negedge clk_sys);
        chk("valid", 4'(decode_valid), 4'h1);
        chk("class", 4'(op_class), 4'(c));
        chk("fault", 4'(invalid_opcode_exception), 4'(c == EODU_OP_FAULT));
        if (c != EODU_OP_FAULT) begin
            chk("sel", op_selector, sl);
            chk("form", 4'(op_form), c == EODU_OP_JCC ? 4'h1 : c == EODU_OP_SETCC ? 4'h2 : 4'h3);
        end
    endtask : run
    task t_cond();
        fm.put(8'h8A);
        for (int i = 0; i < 8; i++) begin
            run(8'h88 + 8'(i), 8'h00, 1'b0, EODU_OP_JCC, 4'h8 + 4'(i));
            run(8'h98 + 8'(i), 8'h00, 1'b0, EODU_OP_SETCC, 4'h8 + 4'(i));
        end
    endtask : t_cond
    task t_grp();
        logic ok;
        for (int k = 0; k < 4; k++) for (int s = 0; s < 8; s++) begin
            ok = k == 3 ? s > 3 : (s == 2 || s == 6 || (s == 4 && k < 2));
            run(k == 3 ? 8'hBA : 8'h71 + 8'(k), {2'h3, 3'(s), 3'h0}, 1'b1, ok ? (k == 3 ? EODU_OP_BIT_TEST
                : EODU_OP_SHIFT_IMM) : EODU_OP_FAULT, 4'(s));
        end
    endtask : t_grp
    task t_fault();
        logic [47:0] t;
        t = 48'h0BB90087A0FF;
        for (int i = 0; i < 6; i++) run(t[47 - 8 * i -: 8], 8'h00, 1'b0, EODU_OP_FAULT, 4'h0);
    endtask : t_fault
    // Reset, then the scenarios
    initial begin
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        t_cond();
        t_grp();
        t_fault();
        summarize();
    end
    // Watchdog well past the expected run length
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
endmodule : eodu_decoder_tb
`default_nettype wire
